// [hdl/adcr_pkg.sv]
// Register map, field layout and mode encodings for the processing config
package adcr_pkg;
  localparam logic [7:0] ADCR_CH4_DELAY_OFS = 8'h4F;
  localparam logic [7:0] ADCR_PROC_A_OFS = 8'h6B;
  localparam logic [7:0] ADCR_PROC_B_OFS = 8'h6C;
  localparam logic [7:0] ADCR_CH4_DELAY_RST = 8'h00;
  localparam logic [7:0] ADCR_PROC_A_RST = 8'h01;
  localparam logic [7:0] ADCR_PROC_B_RST = 8'h40;
  localparam logic [7:0] ADCR_UNMAPPED_RD = 8'h00;
  // Processing config A fields
  localparam int ADCR_A_VOL_LOCK_BIT = 7;
  localparam int ADCR_A_ENH_ALG_BIT = 6;
  localparam int ADCR_A_DECI_LSB = 4;
  localparam int ADCR_A_SUM_LSB = 2;
  localparam int ADCR_A_HPF_LSB = 0;
  // Processing config B fields
  localparam int ADCR_B_GANG_BIT = 7;
  localparam int ADCR_B_BIQ_LSB = 5;
  localparam int ADCR_B_NOSTEP_BIT = 4;
  localparam int ADCR_B_SEL_BIT = 3;
  localparam int ADCR_B_RSVD_BIT = 2;
  localparam int ADCR_B_COMP_BIT = 1;
  localparam int ADCR_B_CLIP_BIT = 0;
  localparam int ADCR_NUM_CH = 4;
  localparam int ADCR_DELAY_MAX = 255;

  typedef enum logic [1:0] {
    ADCR_DECI_LINEAR = 2'h0,
    ADCR_DECI_LOW_LAT = 2'h1,
    ADCR_DECI_ULTRA_LOW = 2'h2,
    ADCR_DECI_RSVD = 2'h3
  } adcr_deci_t;

  typedef enum logic [1:0] {
    ADCR_HPF_PROGRAMMABLE = 2'h0,
    ADCR_HPF_CUT_00025 = 2'h1,
    ADCR_HPF_CUT_0002 = 2'h2,
    ADCR_HPF_CUT_0008 = 2'h3
  } adcr_hpf_t;

  // Gray order along off -> enhancer -> agc -> compression
  typedef enum logic [1:0] {
    ADCR_DYN_OFF = 2'h0,
    ADCR_DYN_ENHANCER = 2'h1,
    ADCR_DYN_AGC = 2'h3,
    ADCR_DYN_COMPRESS = 2'h2
  } adcr_dyn_t;
endpackage : adcr_pkg

// [hdl/adcr_regs.sv]
// Processing configuration registers with channel-4 delay and mode decode
//
// Summary of operation
// R1: Channel 4 delayed by 0..255 modulator cycles from 8-bit field; reset 0.
// R2: Volume lock bit set blocks volume changes while converter powered.
// R3: Enhanced bit picks enhanced gain-management algorithms; resets to 0.
// R4: Decimation field: linear, low latency, ultra-low; value 3 reserved.
// R5: Summation field 1 outputs average of channels 1 and 2; 0 off.
// R6: High-pass field 1..3 fixed cutoffs; 0 programmable IIR; resets to 1.
// R7: Volume gang makes every active channel use channel 1 volume.
// R8: Biquad count field gives 0..3 biquads per channel; resets to 2.
// R9: Volume, mute and unmute soft-step unless soft-step disable is set.
// R10: Without compression, select bit picks enhancer (0) or gain control (1).
// R11: Compression enable forces compression, excluding enhancer and AGC.
// R12: Compression acts like enhancer but without compensating digital gain.
// R13: Clip avoidance compresses above threshold when gain over 0 dB, dynamic.
// R14: Software writes only reset value into reserved config B bit 2.
// R15: Every field reads back last write and resets to documented value.
module adcr_regs
  import adcr_pkg::*;
#(
  parameter int CH_NUM = adcr_pkg::ADCR_NUM_CH,
  parameter int DELAY_MAX = adcr_pkg::ADCR_DELAY_MAX
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic mod_clk_en,
  input wire logic ch4_in,
  output logic ch4_out,
  input wire logic adc_powered,
  input wire logic volume_change_req,
  output logic volume_change_accept,
  input wire logic [7:0] first_channel_volume,
  input wire logic [CH_NUM*8-1:0] per_channel_volume,
  output logic [CH_NUM*8-1:0] effective_volume,
  input wire logic [CH_NUM-1:0] channel_dynamic_processing_enable,
  input wire logic [CH_NUM-1:0] gain_above_0db,
  output adcr_pkg::adcr_dyn_t [CH_NUM-1:0] dynamic_mode,
  output logic [CH_NUM-1:0] gain_compensation_en,
  output logic [CH_NUM-1:0] clip_avoid_active,
  output logic enhanced_algorithm_select,
  output adcr_pkg::adcr_deci_t decimation_response_select,
  output logic [1:0] channel_summation_mode,
  output logic sum_ch12_average,
  output adcr_pkg::adcr_hpf_t highpass_select,
  output logic [1:0] biquad_count,
  output logic soft_step_en
);
  import adcr_pkg::*;

  logic [7:0] ch4_delay_r;
  logic [7:0] proc_a_r;
  logic [7:0] proc_b_r;
  logic [7:0] rdata_nxt;
  logic [7:0] tap_sel;
  logic [DELAY_MAX-1:0] delay_line_r;
  logic [DELAY_MAX-1:0] tap_in;
  logic ch4_nxt;
  logic runtime_volume_lock;
  logic volume_gang;
  logic compression_enable;
  logic enhancer_gain_control_select;
  logic clip_avoidance_enable;
  logic volume_locked;

  assign runtime_volume_lock = proc_a_r[ADCR_A_VOL_LOCK_BIT];
  assign volume_gang = proc_b_r[ADCR_B_GANG_BIT];
  assign compression_enable = proc_b_r[ADCR_B_COMP_BIT];
  assign enhancer_gain_control_select = proc_b_r[ADCR_B_SEL_BIT];
  assign clip_avoidance_enable = proc_b_r[ADCR_B_CLIP_BIT];
  assign volume_locked = runtime_volume_lock && adc_powered;
  assign tap_in = {delay_line_r[DELAY_MAX-2:0], ch4_in};
  assign tap_sel = ch4_delay_r - 8'h01;

  // Channel 4 delay setting
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch4_delay_r <= ADCR_CH4_DELAY_RST; // R1 R15
    end else if (reg_wr && (reg_addr == ADCR_CH4_DELAY_OFS)) begin
      ch4_delay_r <= reg_wdata; // R15
    end
  end

  // Processing config A
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      proc_a_r <= ADCR_PROC_A_RST; // R3 R6 R15
    end else if (reg_wr && (reg_addr == ADCR_PROC_A_OFS)) begin
      proc_a_r <= reg_wdata; // R15
    end
  end

  // Processing config B, reserved bit kept as written
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      proc_b_r <= ADCR_PROC_B_RST; // R8 R15
    end else if (reg_wr && (reg_addr == ADCR_PROC_B_OFS)) begin
      proc_b_r <= reg_wdata; // R14 R15
    end
  end

  // Read multiplexer
  always_comb begin
    case (reg_addr)
      ADCR_CH4_DELAY_OFS: rdata_nxt = ch4_delay_r; // R15
      ADCR_PROC_A_OFS: rdata_nxt = proc_a_r; // R15
      ADCR_PROC_B_OFS: rdata_nxt = proc_b_r; // R15
      default: rdata_nxt = ADCR_UNMAPPED_RD;
    endcase
  end

  // Read valid, one cycle after strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt; // R15
    end
  end

  // Channel 4 delay line, one tap per modulator cycle
  genvar ti;
  generate
    for (ti = 0; ti < DELAY_MAX; ti++) begin : g_tap
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          delay_line_r[ti] <= 1'b0;
        end else if (mod_clk_en) begin
          delay_line_r[ti] <= tap_in[ti]; // R1
        end
      end
    end
  endgenerate

  // Tap 0 is the current input: zero setting adds no delay
  always_comb begin
    if (ch4_delay_r == 8'h00) begin
      ch4_nxt = ch4_in; // R1
    end else begin
      ch4_nxt = delay_line_r[tap_sel]; // R1
    end
  end

  // Channel 4 output register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch4_out <= 1'b0;
    end else begin
      ch4_out <= ch4_nxt; // R1
    end
  end

  // Volume change gating
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      volume_change_accept <= 1'b0;
    end else begin
      volume_change_accept <= volume_change_req && !volume_locked; // R2
    end
  end

  // Enhanced algorithm select
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enhanced_algorithm_select <= ADCR_PROC_A_RST[ADCR_A_ENH_ALG_BIT];
    end else begin
      enhanced_algorithm_select <= proc_a_r[ADCR_A_ENH_ALG_BIT]; // R3
    end
  end

  // Decimation response
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      decimation_response_select <=
        adcr_deci_t'(ADCR_PROC_A_RST[ADCR_A_DECI_LSB +: 2]);
    end else begin
      decimation_response_select <=
        adcr_deci_t'(proc_a_r[ADCR_A_DECI_LSB +: 2]); // R4
    end
  end

  // Channel summation mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_summation_mode <= ADCR_PROC_A_RST[ADCR_A_SUM_LSB +: 2];
    end else begin
      channel_summation_mode <= proc_a_r[ADCR_A_SUM_LSB +: 2]; // R5
    end
  end

  // Channels 1 and 2 averaged
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_ch12_average <= (ADCR_PROC_A_RST[ADCR_A_SUM_LSB +: 2] == 2'h1);
    end else begin
      sum_ch12_average <= (proc_a_r[ADCR_A_SUM_LSB +: 2] == 2'h1); // R5
    end
  end

  // High-pass selection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      highpass_select <= adcr_hpf_t'(ADCR_PROC_A_RST[ADCR_A_HPF_LSB +: 2]);
    end else begin
      highpass_select <= adcr_hpf_t'(proc_a_r[ADCR_A_HPF_LSB +: 2]); // R6
    end
  end

  // Biquad count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      biquad_count <= ADCR_PROC_B_RST[ADCR_B_BIQ_LSB +: 2];
    end else begin
      biquad_count <= proc_b_r[ADCR_B_BIQ_LSB +: 2]; // R8
    end
  end

  // Soft-step enable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_step_en <= !ADCR_PROC_B_RST[ADCR_B_NOSTEP_BIT];
    end else begin
      soft_step_en <= !proc_b_r[ADCR_B_NOSTEP_BIT]; // R9
    end
  end

  // Per-channel volume source and dynamic processing mode
  genvar gi;
  generate
    for (gi = 0; gi < CH_NUM; gi++) begin : g_ch
      adcr_dyn_t mode_nxt;
      logic [7:0] vol_nxt;
      logic comp_nxt;
      logic clip_nxt;

      always_comb begin
        if (!channel_dynamic_processing_enable[gi] && !compression_enable) begin
          mode_nxt = ADCR_DYN_OFF;
        end else if (compression_enable) begin
          mode_nxt = ADCR_DYN_COMPRESS; // R11
        end else if (enhancer_gain_control_select) begin
          mode_nxt = ADCR_DYN_AGC; // R10
        end else begin
          mode_nxt = ADCR_DYN_ENHANCER; // R10
        end
      end

      assign vol_nxt = volume_gang ? first_channel_volume :
        per_channel_volume[gi*8 +: 8]; // R7
      assign comp_nxt = (mode_nxt == ADCR_DYN_ENHANCER) ||
        (mode_nxt == ADCR_DYN_AGC); // R12
      assign clip_nxt = clip_avoidance_enable && gain_above_0db[gi] &&
        (mode_nxt != ADCR_DYN_OFF); // R13

      // Volume source
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          effective_volume[gi*8 +: 8] <= 8'h00;
        end else begin
          effective_volume[gi*8 +: 8] <= vol_nxt; // R7
        end
      end

      // Dynamic processing mode
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          dynamic_mode[gi] <= ADCR_DYN_OFF;
        end else begin
          dynamic_mode[gi] <= mode_nxt; // R10 R11
        end
      end

      // Compensating gain
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          gain_compensation_en[gi] <= 1'b0;
        end else begin
          gain_compensation_en[gi] <= comp_nxt; // R12
        end
      end

      // Clip avoidance
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          clip_avoid_active[gi] <= 1'b0;
        end else begin
          clip_avoid_active[gi] <= clip_nxt; // R13
        end
      end
    end
  endgenerate
endmodule // adcr_regs

// [verification/adcr_regs_props.sv]
// Checker for the processing config register bank
module adcr_regs_props
  import adcr_pkg::*;
#(
  parameter int CH_NUM = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic adc_powered,
  input wire logic volume_change_req,
  input wire logic volume_change_accept,
  input wire logic [CH_NUM-1:0] gain_above_0db,
  input wire adcr_pkg::adcr_dyn_t [CH_NUM-1:0] dynamic_mode,
  input wire logic [CH_NUM-1:0] gain_compensation_en,
  input wire logic [CH_NUM-1:0] clip_avoid_active,
  input wire logic [1:0] channel_summation_mode,
  input wire logic sum_ch12_average,
  input wire adcr_pkg::adcr_hpf_t highpass_select,
  input wire logic [1:0] biquad_count,
  input wire logic soft_step_en
);
  timeunit 1ns / 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr_a;
    reg_wr && reg_addr == ADCR_PROC_A_OFS ##1 !reg_wr;
  endsequence
  sequence s_wr_b;
    reg_wr && reg_addr == ADCR_PROC_B_OFS ##1 !reg_wr;
  endsequence
  property p_hpf;
    s_wr_a |=> highpass_select == $past(reg_wdata[1:0], 2);
  endproperty
  a_hpf: assert property (p_hpf) else $error("hpf wrong");
  property p_bq;
    s_wr_b |=> biquad_count == $past(reg_wdata[6:5], 2)
      && soft_step_en != $past(reg_wdata[4], 2);
  endproperty
  a_bq: assert property (p_bq) else $error("biquad or step wrong");
  property p_rv;
    reg_rvalid == $past(reg_rd);
  endproperty
  a_rv: assert property (p_rv) else $error("rvalid wrong");
  property p_unl;
    volume_change_req && !adc_powered |=> volume_change_accept;
  endproperty
  a_unl: assert property (p_unl) else $error("volume refused");
  property p_avg;
    sum_ch12_average == (channel_summation_mode == 2'h1);
  endproperty
  a_avg: assert property (p_avg) else $error("average wrong");
  property p_comp;
    gain_compensation_en[0]
      == (dynamic_mode[0] inside {ADCR_DYN_ENHANCER, ADCR_DYN_AGC});
  endproperty
  a_comp: assert property (p_comp) else $error("comp gain wrong");
  property p_all;
    dynamic_mode[0] == ADCR_DYN_COMPRESS
      |-> dynamic_mode[CH_NUM-1] == ADCR_DYN_COMPRESS;
  endproperty
  a_all: assert property (p_all) else $error("compress not global");
  property p_clip;
    clip_avoid_active[0]
      |-> dynamic_mode[0] != ADCR_DYN_OFF && $past(gain_above_0db[0]);
  endproperty
  a_clip: assert property (p_clip) else $error("clip wrong");
endmodule // adcr_regs_props

bind adcr_regs adcr_regs_props #(.CH_NUM(CH_NUM)) u_props (.*);

// [verification/tb.sv]
// Self-checking bench for the processing config register bank
module tb;
  timeunit 1ns / 1ps;
  import adcr_pkg::*;
  logic core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, mod_clk_en = 0;
  logic ch4_in = 0, adc_powered = 0, volume_change_req = 0, reg_rvalid;
  logic [7:0] reg_addr = '0, reg_wdata = '0, first_channel_volume = '0, d;
  logic [31:0] per_channel_volume = '0, effective_volume, lf = 32'hC5AA;
  logic [3:0] channel_dynamic_processing_enable = '0, gain_above_0db = '0;
  logic [3:0] gain_compensation_en, clip_avoid_active;
  logic [7:0] reg_rdata, q[$];
  logic ch4_out, volume_change_accept, enhanced_algorithm_select, h[$];
  logic sum_ch12_average, soft_step_en, ex, hv;
  logic [1:0] channel_summation_mode, biquad_count;
  adcr_dyn_t [3:0] dynamic_mode;
  adcr_dyn_t m;
  adcr_deci_t decimation_response_select;
  adcr_hpf_t highpass_select;
  int mismatches = 0, checks_done = 0;
  adcr_regs DUT (.*);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1;
    q.push_back(e);
    @(negedge core_clk);
    reg_rd = 0;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial forever #4 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    if (reg_rvalid === 1'b1) check("rdata", reg_rdata, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    final_report;
  end
  initial begin
    repeat (8) @(negedge core_clk);
    arst_n = 1;
    rd(ADCR_CH4_DELAY_OFS, ADCR_CH4_DELAY_RST);
    rd(ADCR_PROC_A_OFS, ADCR_PROC_A_RST);
    rd(ADCR_PROC_B_OFS, ADCR_PROC_B_RST);
    rd(8'h50, ADCR_UNMAPPED_RD);
    check("enh", enhanced_algorithm_select, 0);
    for (int i = 0; i < 8; i++) begin
      d = i < 4 ? 8'(i * 8'h55) : lf[7:0];
      if (d[5:4] == 2'h3) d[5:4] = 2'h2;
      d[3] = 1'b0;
      wr(ADCR_PROC_A_OFS, d);
      check("deci", decimation_response_select, d[5:4]);
      check("sum", channel_summation_mode, d[3:2]);
      check("avg", sum_ch12_average, d[3:2] == 2'h1);
      check("hpf", highpass_select, d[1:0]);
      check("enh", enhanced_algorithm_select, d[6]);
      adc_powered = lf[8];
      volume_change_req = 1;
      lf = nxt(lf);
      @(negedge core_clk);
      check("acc", volume_change_accept, !(d[7] & adc_powered));
      volume_change_req = 0;
      rd(ADCR_PROC_A_OFS, d);
    end
    for (int i = 0; i < 16; i++) begin
      d = {lf[7], i[2:1], lf[4], i[3], 1'b0, i[1], i[0]};
      channel_dynamic_processing_enable = lf[11:8];
      gain_above_0db = lf[15:12];
      first_channel_volume = lf[23:16];
      per_channel_volume = {lf[15:0], lf[31:16]};
      lf = nxt(lf);
      wr(ADCR_PROC_B_OFS, d);
      check("bq", biquad_count, d[6:5]);
      check("step", soft_step_en, !d[4]);
      for (int k = 0; k < 4; k++) begin
        m = d[1] ? ADCR_DYN_COMPRESS : !channel_dynamic_processing_enable[k]
          ? ADCR_DYN_OFF : d[3] ? ADCR_DYN_AGC : ADCR_DYN_ENHANCER;
        check("mode", dynamic_mode[k], m);
        check("gcomp", gain_compensation_en[k], m inside {1, 3});
        check("clip", clip_avoid_active[k], d[0] & gain_above_0db[k] & |m);
        check("vol", effective_volume[k*8+:8],
          d[7] ? first_channel_volume : per_channel_volume[k*8+:8]);
      end
      rd(ADCR_PROC_B_OFS, d);
    end
    for (int n = 0; n < 256; n += 85) begin
      wr(ADCR_CH4_DELAY_OFS, 8'(n));
      h.delete();
      hv = 1'b0;
      for (int c = 0; c < 3 * n + 12; c++) begin
        if (hv) check("ch4", ch4_out, ex);
        ch4_in = lf[0];
        mod_clk_en = lf[1] | lf[2];
        hv = n == 0 || h.size() >= n;
        ex = n == 0 ? ch4_in : hv ? h[n - 1] : 1'b0;
        if (mod_clk_en) h.push_front(ch4_in);
        lf = nxt(lf);
        @(negedge core_clk);
      end
      mod_clk_en = 0;
    end
    arst_n = 0;
    @(negedge core_clk);
    arst_n = 1;
    rd(ADCR_PROC_B_OFS, ADCR_PROC_B_RST);
    rd(ADCR_PROC_A_OFS, ADCR_PROC_A_RST);
    rd(ADCR_CH4_DELAY_OFS, ADCR_CH4_DELAY_RST);
    check("hpf", highpass_select, ADCR_PROC_A_RST[1:0]);
    check("bq", biquad_count, ADCR_PROC_B_RST[6:5]);
    @(negedge core_clk);
    check("pending", q.size(), 0);
    final_report;
  end
endmodule // tb
